// [rtl/alu_pkg.sv]
package alu_pkg;

  // ----------------------------------------------------------------------
  // widths and limits
  // ----------------------------------------------------------------------
  localparam int          DATA_W     = 8;
  localparam int          RF_DEPTH   = 32;
  localparam int          RF_AW      = 5;
  localparam logic [7:0]  ALL_ONES   = 8'hff;
  localparam logic [7:0]  IO_BIT_MAX = 8'h1f;

  // status flag positions inside the flag vector
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam logic [5:0] FLAGS_RST = 6'h00;

  // word operations take two cycles
  localparam int WORD_CYCLES = 2;

  // ----------------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_ADD                  = 5'h00,
    OP_ADD_CARRY            = 5'h01,
    OP_ADD_IMMEDIATE_WORD   = 5'h02,
    OP_SUB                  = 5'h03,
    OP_SUBTRACT_IMMEDIATE   = 5'h04,
    OP_SUBTRACT_WITH_CARRY  = 5'h05,
    OP_SUBTRACT_CARRY_IMM   = 5'h06,
    OP_SUBTRACT_IMM_WORD    = 5'h07,
    OP_AND                  = 5'h08,
    OP_AND_IMMEDIATE        = 5'h09,
    OP_OR                   = 5'h0a,
    OP_OR_IMMEDIATE         = 5'h0b,
    OP_EXCLUSIVE_OR         = 5'h0c,
    OP_BITWISE_INVERT       = 5'h0d,
    OP_SET_BITS_MASK        = 5'h0e,
    OP_CLEAR_BITS_MASK      = 5'h0f,
    OP_TEST_ZERO_OR_MINUS   = 5'h10,
    OP_IO_BIT_SET           = 5'h11,
    OP_IO_BIT_CLEAR         = 5'h12
  } alu_op_e;

  // one instruction as issued by the core
  typedef struct packed {
    alu_op_e    op;
    logic [4:0] rd;   // destination (low register for word ops)
    logic [4:0] rr;   // source register
    logic [7:0] imm;  // constant, mask, or io address for bit ops
    logic [2:0] bit_sel;
  } alu_req_s;

  // io bus toward flag registers
  typedef struct packed {
    logic       wr;
    logic [4:0] addr;
    logic [7:0] data;
  } alu_io_s;

endpackage

// [rtl/alu_regfile.sv]
`timescale 1ns/1ns
module alu_regfile #(
  parameter int DEPTH = 32,
  parameter int AW    = 5,
  parameter int DW    = 8
) (
  input  wire logic          ref_clk,   // core clock
  input  wire logic          clk_en,    // freeze when low
  input  wire logic          we,        // write strobe
  input  wire logic [AW-1:0] waddr,     // write address
  input  wire logic [DW-1:0] wdata,     // write data
  input  wire logic [AW-1:0] raddr_a,   // read port a
  input  wire logic [AW-1:0] raddr_b,   // read port b
  output logic      [DW-1:0] rdata_a,   // registered read a
  output logic      [DW-1:0] rdata_b    // registered read b
);

  logic [DW-1:0] mem [DEPTH];

  // ----------------------------------------------------------------------
  // write and registered read; no reset, contents are software state
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end

endmodule // alu_regfile

// [rtl/alu_unit.sv]
`timescale 1ns/1ns
// How it works
// [RULE1] add registers, optional carry, flags, one cycle
// [RULE2] add immediate to register pair, two cycles
// [RULE3] subtract register or constant, flags, one cycle
// [RULE4] subtract register and carry, one cycle
// [RULE5] subtract constant and carry, one cycle
// [RULE6] subtract immediate from register pair, two cycles
// [RULE7] and with register or constant, z n v
// [RULE8] or, xor with register, or constant
// [RULE9] invert: ff minus value, z c n v
// [RULE10] set bits by mask, z n v
// [RULE11] clear bits by inverted mask, z n v
// [RULE12] test: and with itself, no write
// [RULE13] io flags clear on writing one
// [RULE14] io bit ops rewrite whole register, low addresses
// [RULE15] software writes zero to reserved bits
// [RULE16] sign is negative xor overflow, updated by word ops only
module alu_unit
  import alu_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input  wire logic                     ref_clk,   // core clock, 25 MHz
  input  wire logic                     reset_n,   // sync reset, low
  input  wire logic                     clk_en,    // freeze when low
  input  wire alu_pkg::alu_req_s        req,       // instruction
  input  wire logic                     req_valid, // issue strobe
  input  wire logic [7:0]               io_rdata,  // io register read data
  output alu_pkg::alu_io_s              io_out,    // io write toward flags
  output logic [4:0]                    io_raddr_r,// io address being read
  output logic [5:0]                    flags_r,   // status flags
  output logic                          busy_r,    // operation in progress
  output logic                          done_r,    // one-cycle completion
  output logic [7:0]                    result_r   // last result byte
);
  import alu_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b10,
    ST_HIGH = 2'b11
  } alu_st_e;

  alu_st_e    st_r;
  alu_req_s   cur_r;
  logic       low_c_r;         // carry out of the low byte of a word op
  logic       low_z_r;         // low byte zero
  logic       rf_we;
  logic [4:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic [4:0] ra_sel;
  logic [4:0] rb_sel;
  logic [7:0] rd_v;
  logic [7:0] rr_v;

  alu_regfile #(.DEPTH(DEPTH), .AW(RF_AW), .DW(DATA_W)) u_rf (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .we      (rf_we),
    .waddr   (rf_waddr),
    .wdata   (rf_wdata),
    .raddr_a (ra_sel),
    .raddr_b (rb_sel),
    .rdata_a (rd_v),
    .rdata_b (rr_v)
  );

  function automatic logic is_word(input alu_op_e op);
    return op == OP_ADD_IMMEDIATE_WORD || op == OP_SUBTRACT_IMM_WORD;
  endfunction

  function automatic logic is_io(input alu_op_e op);
    return op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR;
  endfunction

  // read addresses: the read port is registered, so the high byte of a
  // pair is addressed during the low-byte cycle to be ready for the next
  assign ra_sel = (st_r == ST_READ && is_word(cur_r.op)) ?
                  cur_r.rd + 5'd1 : (st_r == ST_IDLE ? req.rd : cur_r.rd);
  assign rb_sel = (st_r == ST_IDLE) ? req.rr : cur_r.rr;

  // ----------------------------------------------------------------------
  // byte datapath
  // ----------------------------------------------------------------------
  logic [8:0] sum;
  logic [4:0] hsum;
  logic [7:0] opb;
  logic [7:0] res;
  logic [5:0] fl;
  logic       wr_back;
  logic       cin;
  logic       sub;
  logic       arith;
  logic       use_imm;

  always_comb begin
    opb     = 8'h00;
    sub     = 1'b0;
    cin     = 1'b0;
    arith   = 1'b1;
    use_imm = 1'b0;
    wr_back = 1'b1;
    res     = 8'h00;
    fl      = flags_r;
    unique case (cur_r.op)
      OP_ADD, OP_ADD_CARRY: begin
        cin = (cur_r.op == OP_ADD_CARRY) & flags_r[FLG_C]; // RULE1
      end
      OP_SUB, OP_SUBTRACT_IMMEDIATE: begin
        sub     = 1'b1;                                    // RULE3
        use_imm = (cur_r.op == OP_SUBTRACT_IMMEDIATE);
      end
      OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_CARRY_IMM: begin
        sub     = 1'b1;
        cin     = flags_r[FLG_C];                          // RULE4
        use_imm = (cur_r.op == OP_SUBTRACT_CARRY_IMM);     // RULE5
      end
      OP_ADD_IMMEDIATE_WORD, OP_SUBTRACT_IMM_WORD: begin
        sub = (cur_r.op == OP_SUBTRACT_IMM_WORD);
        use_imm = (st_r == ST_READ);     // high byte adds or subtracts only the carry
        cin = (st_r == ST_EXEC) ? low_c_r : 1'b0;
      end
      default: begin
        arith = 1'b0;
      end
    endcase
    opb = use_imm ? cur_r.imm :
          (is_word(cur_r.op) ? 8'h00 : rr_v);
    if (sub) begin
      sum  = {1'b0, rd_v} - {1'b0, opb} - {8'h00, cin};
      hsum = {1'b0, rd_v[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
    end else begin
      sum  = {1'b0, rd_v} + {1'b0, opb} + {8'h00, cin};
      hsum = {1'b0, rd_v[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    end
    if (arith) begin
      res        = sum[7:0];
      fl[FLG_C]  = sum[8];
      fl[FLG_H]  = hsum[4];
      fl[FLG_V]  = sub ? (rd_v[7] ^ opb[7]) & (res[7] ^ rd_v[7])
                       : ~(rd_v[7] ^ opb[7]) & (res[7] ^ rd_v[7]);
    end else begin
      fl[FLG_V] = 1'b0;                                   // RULE7
      unique case (cur_r.op)
        OP_AND:                res = rd_v & rr_v;          // RULE7
        OP_AND_IMMEDIATE:      res = rd_v & cur_r.imm;     // RULE7
        OP_OR:                 res = rd_v | rr_v;          // RULE8
        OP_OR_IMMEDIATE:       res = rd_v | cur_r.imm;     // RULE8
        OP_EXCLUSIVE_OR:       res = rd_v ^ rr_v;          // RULE8
        OP_BITWISE_INVERT: begin
          res       = ALL_ONES - rd_v;                     // RULE9
          fl[FLG_C] = 1'b1;                                // RULE9
        end
        OP_SET_BITS_MASK:      res = rd_v | cur_r.imm;     // RULE10
        OP_CLEAR_BITS_MASK:    res = rd_v & (ALL_ONES - cur_r.imm); // RULE11
        OP_TEST_ZERO_OR_MINUS: begin
          res     = rd_v & rd_v;                           // RULE12
          wr_back = 1'b0;                                  // RULE12
        end
        default:               res = 8'h00;
      endcase
    end
    fl[FLG_N] = res[7];
    // word ops: zero covers both bytes, h is left alone
    if (is_word(cur_r.op)) begin
      fl[FLG_Z] = (res == 8'h00) & (st_r == ST_READ ? 1'b1 : low_z_r);
      fl[FLG_H] = flags_r[FLG_H];
      fl[FLG_S] = fl[FLG_N] ^ fl[FLG_V];                   // RULE16
      if (st_r == ST_EXEC) begin
        fl[FLG_C] = sub ? res[7] & ~rd_v[7] : ~res[7] & rd_v[7];
        fl[FLG_V] = sub ? ~res[7] & rd_v[7] : res[7] & ~rd_v[7];
        fl[FLG_S] = fl[FLG_N] ^ fl[FLG_V];                 // RULE16
      end
    end else begin
      fl[FLG_Z] = (res == 8'h00);
    end
  end

  // ----------------------------------------------------------------------
  // io bit set or clear: read the whole register and write it all back,
  // so a flag read as one is written as one and thereby cleared
  // ----------------------------------------------------------------------
  logic [7:0] io_wval;
  always_comb begin
    io_wval = io_rdata;                                    // RULE14
    io_wval[cur_r.bit_sel] = (cur_r.op == OP_IO_BIT_SET);  // RULE13
  end

  // ----------------------------------------------------------------------
  // sequencer: idle, operand read and execute, second byte of a word op, completion
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_r  <= ST_IDLE;
      cur_r <= '0;
    end else if (clk_en) begin
      unique case (st_r)
        ST_IDLE: if (req_valid) begin
          cur_r <= req;
          st_r  <= ST_READ;
        end
        ST_READ: st_r <= is_word(cur_r.op) ? ST_EXEC : ST_HIGH; // RULE2 RULE6
        ST_EXEC: st_r <= ST_HIGH;
        ST_HIGH: st_r <= ST_IDLE;
      endcase
    end
  end

  // register file write from the execute cycles
  always_comb begin
    rf_we    = 1'b0;
    rf_waddr = cur_r.rd;
    rf_wdata = res;
    if (clk_en && !is_io(cur_r.op) && wr_back) begin
      if (st_r == ST_READ) begin
        rf_we = 1'b1;                                      // RULE1
      end else if (st_r == ST_EXEC) begin
        rf_we    = 1'b1;                                   // RULE2 RULE6
        rf_waddr = cur_r.rd + 5'd1;
      end
    end
  end

  // flags, result and handshake outputs
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flags_r    <= FLAGS_RST;
      result_r   <= 8'h00;
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
      low_c_r    <= 1'b0;
      low_z_r    <= 1'b0;
      io_out     <= '0;
      io_raddr_r <= 5'h00;
    end else if (clk_en) begin
      done_r <= 1'b0;
      io_out <= '0;
      busy_r <= (st_r == ST_IDLE) ? req_valid : (st_r != ST_HIGH);
      if (st_r == ST_IDLE && req_valid) begin
        io_raddr_r <= req.imm[4:0];
      end
      if (st_r == ST_READ) begin
        if (is_io(cur_r.op)) begin
          // addresses above the bit-op range are ignored
          io_out.wr   <= (cur_r.imm <= IO_BIT_MAX);        // RULE14
          io_out.addr <= cur_r.imm[4:0];
          io_out.data <= io_wval;
        end else begin
          flags_r  <= fl;
          result_r <= res;
          low_c_r  <= sum[8];
          low_z_r  <= (res == 8'h00);
        end
      end
      if (st_r == ST_EXEC) begin
        flags_r  <= fl;
        result_r <= res;
      end
      if (st_r == ST_HIGH) begin
        done_r <= 1'b1;
      end
    end
  end

endmodule // alu_unit

// [verif/alu_unit_properties.sv]
`timescale 1ns/1ns
module alu_unit_properties (
  input wire logic              ref_clk,    // clock
  input wire logic              reset_n,    // reset
  input wire logic              clk_en,     // run
  input wire alu_pkg::alu_req_s req,        // op
  input wire logic              req_valid,  // issue
  input wire logic [7:0]        io_rdata,   // io read
  input wire alu_pkg::alu_io_s  io_out,     // io write
  input wire logic [4:0]        io_raddr_r, // io addr
  input wire logic [5:0]        flags_r,    // flags
  input wire logic              busy_r,     // busy
  input wire logic              done_r,     // done
  input wire logic [7:0]        result_r    // result
);
  import alu_pkg::*;
  alu_op_e    op_r;
  logic [2:0] bit_r;
  logic       word_r;
  logic       take;
  logic       is_word;
  assign take = req_valid && !busy_r && clk_en;
  assign is_word = req.op inside {OP_ADD_IMMEDIATE_WORD, OP_SUBTRACT_IMM_WORD};
  // op in flight, so completion checks know what ran
  always_ff @(posedge ref_clk) begin
    if (take) begin
      op_r   <= req.op;
      bit_r  <= req.bit_sel;
      word_r <= is_word;
    end
  end
  // a freeze stretches every count, so it aborts the checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n || !clk_en);
  byte_timing_a: assert property (take && !is_word |=>
    busy_r ##1 busy_r ##1 (done_r && !busy_r)) else $error("byte timing");
  word_timing_a: assert property (take && is_word |=>
    busy_r [*3] ##1 done_r) else $error("word timing");
  done_pulse_a: assert property (done_r |=> !done_r)
    else $error("done long");
  idle_hold_a: assert property (!busy_r |=>
    $stable(result_r) && $stable(flags_r)) else $error("idle change");
  word_sign_a: assert property (done_r && word_r |->
    flags_r[FLG_S] == (flags_r[FLG_N] ^ flags_r[FLG_V])) else $error("sign");
  byte_zero_a: assert property (done_r && !word_r && op_r < OP_IO_BIT_SET
    |-> flags_r[FLG_Z] == (result_r == 8'h00)) else $error("zero flag");
  invert_flags_a: assert property (done_r && op_r == OP_BITWISE_INVERT
    |-> flags_r[FLG_C] && !flags_r[FLG_V]) else $error("invert flags");
  io_addr_a: assert property (io_out.wr |-> busy_r &&
    io_out.addr == io_raddr_r && op_r >= OP_IO_BIT_SET) else $error("io addr");
  io_rmw_a: assert property (io_out.wr |-> io_out.data ==
    (op_r == OP_IO_BIT_SET ? $past(io_rdata) | (8'h01 << bit_r)
     : $past(io_rdata) & ~(8'h01 << bit_r))) else $error("io data");
  reset_zero_a: assert property (disable iff (1'b0) !reset_n && clk_en |=>
    result_r == 8'h00 && flags_r == 6'h00 && !busy_r) else $error("reset");
endmodule // alu_unit_properties
bind alu_unit alu_unit_properties chk_u (.ref_clk(ref_clk),
  .reset_n(reset_n), .clk_en(clk_en), .req(req), .req_valid(req_valid),
  .io_rdata(io_rdata), .io_out(io_out), .io_raddr_r(io_raddr_r),
  .flags_r(flags_r), .busy_r(busy_r), .done_r(done_r), .result_r(result_r));

// [verif/test_arith_logic_instr_unit.sv]
`timescale 1ns/1ns
module test_arith_logic_instr_unit;
  import alu_pkg::*;
  logic       ref_clk = 0, reset_n = 0, clk_en = 1, req_valid = 0;
  alu_req_s   req = '0;
  logic [7:0] io_rdata = 8'h00;
  alu_io_s    io_out;
  logic [4:0] io_raddr_r;
  logic [5:0] flags_r, mf = 6'h00;
  logic       busy_r, done_r;
  logic [7:0] result_r, rf [32], io_mem [32];
  logic [31:0] v;
  alu_op_e    op;
  int         bad_count = 0, n_tests = 0, seed = 32'hd0c6705e;
  alu_unit dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .req(req), .req_valid(req_valid), .io_rdata(io_rdata), .io_out(io_out),
    .io_raddr_r(io_raddr_r), .flags_r(flags_r), .busy_r(busy_r),
    .done_r(done_r), .result_r(result_r));
  always #20 ref_clk = ~ref_clk;
  // io registers answer at the falling edge, settled before sampling
  always @(negedge ref_clk) io_rdata <= io_mem[io_raddr_r];
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // ----------------------------------------------------------------
  // one op: issue, wait for done, compare with the bench model
  // ----------------------------------------------------------------
  task automatic run(alu_op_e o, logic [4:0] rd, rr, logic [7:0] k,
                     logic [2:0] b);
    logic [8:0]  s;
    logic [16:0] w;
    logic [7:0]  a, x, r, m, wd;
    logic [4:0]  rh;
    logic        ci, ws;
    int          t;
    @(negedge ref_clk);
    req = '{o, rd, rr, k, b};
    req_valid = 1'b1;
    @(negedge ref_clk);
    req.rd = ~rd;  // held while busy: must be ignored
    t = 0;
    ws = 1'b0;
    wd = 8'h00;
    while (done_r !== 1'b1 && t < 40) begin
      clk_en = ($random(seed) & 3) != 0;
      @(negedge ref_clk);
      req_valid = 1'b0;
      if (io_out.wr === 1'b1) begin
        ws = 1'b1;
        wd = io_out.data;
      end
      t++;
    end
    clk_en = 1'b1;
    chk("done", 8'h01, {7'h0, done_r});
    rh = rd + 5'd1;
    a = rf[rd];
    x = o inside {OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_WITH_CARRY,
                  OP_AND, OP_OR, OP_EXCLUSIVE_OR} ? rf[rr] : k;
    ci = o inside {OP_ADD_CARRY, OP_SUBTRACT_WITH_CARRY,
                   OP_SUBTRACT_CARRY_IMM} && mf[FLG_C];
    m = 8'h01 << b;
    r = a;
    case (o)
      OP_ADD, OP_ADD_CARRY: begin
        s = a + x + ci;
        r = s[7:0];
        mf[FLG_C] = s[8];
        mf[FLG_H] = (a & 15) + (x & 15) + ci > 15;
        mf[FLG_V] = a[7] == x[7] && r[7] != a[7];
      end
      OP_SUB, OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_CARRY,
      OP_SUBTRACT_CARRY_IMM: begin
        s = a - x - ci;
        r = s[7:0];
        mf[FLG_C] = s[8];
        mf[FLG_H] = (a & 15) < (x & 15) + ci;
        mf[FLG_V] = a[7] != x[7] && r[7] != a[7];
      end
      OP_ADD_IMMEDIATE_WORD, OP_SUBTRACT_IMM_WORD: begin
        w = o == OP_ADD_IMMEDIATE_WORD ? {rf[rh], a} + k : {rf[rh], a} - k;
        r = w[15:8];
        mf[FLG_C] = w[16];
        mf[FLG_Z] = w[15:0] == 16'h0000;
        mf[FLG_N] = w[15];
        mf[FLG_V] = o == OP_ADD_IMMEDIATE_WORD ? !rf[rh][7] && w[15]
                    : rf[rh][7] && !w[15];
        mf[FLG_S] = mf[FLG_N] ^ mf[FLG_V];
        rf[rd] = w[7:0];
        rf[rh] = w[15:8];
      end
      OP_AND, OP_AND_IMMEDIATE: r = a & x;
      OP_OR, OP_OR_IMMEDIATE, OP_SET_BITS_MASK: r = a | x;
      OP_EXCLUSIVE_OR: r = a ^ x;
      OP_CLEAR_BITS_MASK: r = a & (8'hff - x);
      OP_BITWISE_INVERT: r = 8'hff - a;
      OP_TEST_ZERO_OR_MINUS: r = a & a;
      default: r = a;
    endcase
    // logic ops clear overflow; invert also forces carry
    if (o >= OP_AND && o <= OP_TEST_ZERO_OR_MINUS) mf[FLG_V] = 1'b0;
    if (o == OP_BITWISE_INVERT) mf[FLG_C] = 1'b1;
    if (o < OP_IO_BIT_SET && !(o inside {OP_ADD_IMMEDIATE_WORD,
        OP_SUBTRACT_IMM_WORD})) begin
      mf[FLG_Z] = r == 8'h00;
      mf[FLG_N] = r[7];
      if (o != OP_TEST_ZERO_OR_MINUS) rf[rd] = r;
    end
    if (o < OP_IO_BIT_SET) begin
      chk("result", r, result_r);
      chk("flags", {2'b0, mf}, {2'b0, flags_r});
    end else begin
      chk("io_wr", {7'h0, k <= 8'h1f}, {7'h0, ws});
      if (ws) chk("io_data", o == OP_IO_BIT_SET ? io_mem[k[4:0]] | m
                  : io_mem[k[4:0]] & ~m, wd);
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 32; i++) io_mem[i] = 8'($random(seed));
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    // no register load exists: clear then set bits to seed each one
    for (int i = 0; i < 32; i++) begin
      run(OP_AND_IMMEDIATE, i[4:0], 5'h0, 8'h00, 3'h0);
      run(OP_OR_IMMEDIATE, i[4:0], 5'h0, 8'($random(seed)), 3'h0);
    end
    // word wrap at both ends
    run(OP_OR_IMMEDIATE, 5'h2, 5'h0, 8'hff, 3'h0);
    run(OP_OR_IMMEDIATE, 5'h3, 5'h0, 8'hff, 3'h0);
    run(OP_ADD_IMMEDIATE_WORD, 5'h2, 5'h0, 8'h01, 3'h0);
    run(OP_SUBTRACT_IMM_WORD, 5'h2, 5'h0, 8'h01, 3'h0);
    repeat (2) begin
      repeat (150) begin
        v = $random(seed);
        op = alu_op_e'(v[4:0] % 5'd19);
        run(op, v[9:5] & 5'h1e, v[14:10], op >= OP_IO_BIT_SET ?
            v[22:15] & 8'h3f : v[22:15], v[25:23]);
      end
      // reset in mid-run: outputs clear, register file keeps contents
      @(negedge ref_clk);
      reset_n = 1'b0;
      @(negedge ref_clk);
      reset_n = 1'b1;
      mf = 6'h00;
      chk("rst_out", 8'h00, {flags_r, busy_r, done_r});
      chk("rst_result", 8'h00, result_r);
    end
    give_verdict();
  end
  initial begin
    #800000;
    bad_count++;
    give_verdict();
  end
endmodule // test_arith_logic_instr_unit
